// ---- rtl/oseic_regs.sv ----
// Overflow summary, error interrupt control and error MSI high address registers.
//
// Contract
// - Per-instance pending bit set while any monitor there has an overflow flag.
// - Overflow summary is read-only at 0x08F0; writes ignored.
// - Four separate summary copies, each showing only its own space.
// - Root and realm summary copies exist only with realm management.
// - Error control bit 0 enables error interrupts; bits 31:1 reserved.
// - Component without error conditions makes error control read zero, ignore writes.
// - Without base partitioning, error control behaves as reserved-zero.
// - Error control is read/write at 0x00F0; root/realm copies need realm management.
// - Four error control copies, each governing its own space's errors.
// - High MSI address register is 32-bit read/write per security space.
// - High address bits 19:0 hold address 51:32; bits 31:20 reserved.
// - High address register exists only when MSI capability is set.
// - Bit 31 flags any cache usage monitor overflow.
// - Bit 30 flags any bandwidth monitor overflow or long overflow.
// - Low address register bits 1:0 read zero, giving a word-aligned address.
module oseic_regs (
	input  wire logic                                   clk_i,
	input  wire logic                                   resetn_i,
	input  wire oseic_pkg::oseic_req_type               req_i,
	output logic                                        ack_o,
	output logic [31:0]                                 rdata_o,
	input  wire oseic_pkg::oseic_oflow_type [3:0]       oflow_i,
	input  wire logic                                   realm_mgmt_present_i,
	input  wire logic                                   partitioning_present_i,
	input  wire logic                                   errors_possible_i,
	input  wire logic                                   error_msi_capable_i,
	input  wire logic                                   error_event_i,
	input  wire oseic_pkg::oseic_space_type             error_space_i,
	output logic [3:0]                                  error_irq_o,
	output logic [3:0][19:0]                            msi_address_upper_o
);
	import oseic_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// All state lives in one packed struct.
	typedef struct packed {
		oseic_space_state_type [3:0] space;
		logic                        ack;
		logic [31:0]                 rdata;
		logic [3:0]                  irq;
	} oseic_state_type;

	oseic_state_type state_q;
	oseic_state_type state_d;

	logic [3:0]  space_live;
	logic        ctrl_live;
	logic [31:0] summary_word [4];

	////////////////////////////////////////////////////////////////////////////
	// Root and realm pages only answer when realm management is present.
	always_comb begin
		space_live = 4'hf;
		if (!realm_mgmt_present_i) begin
			space_live[OSEIC_SPACE_ROOT]  = 1'b0;
			space_live[OSEIC_SPACE_REALM] = 1'b0;
		end
	end

	// Error control is only real when partitioning exists and errors can occur.
	assign ctrl_live = partitioning_present_i && errors_possible_i;

	// Summary word per space, built only from that space's own monitors.
	for (genvar s = 0; s < OSEIC_NUM_SPACES; s++) begin : g_sum
		always_comb begin
			summary_word[s] = 32'h00000000;
			summary_word[s][OSEIC_NUM_INST-1:0] = oflow_i[s].inst_flag;
			summary_word[s][OSEIC_CSU_BIT]  = oflow_i[s].csu_flag;
			summary_word[s][OSEIC_MEMORY_BANDWIDTH_USAGE_BIT] = oflow_i[s].memory_bandwidth_usage_flag;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Decode the access; reads return in the cycle after the request.
	always_comb begin
		state_d       = state_q;
		state_d.ack   = req_i.valid;
		state_d.rdata = 32'h00000000;
		if (req_i.valid && space_live[req_i.space]) begin
			unique case (req_i.offset)
				OSEIC_OFS_OFLOW_SUM: begin
					// Writes fall through untouched: the summary has no storage.
					if (!req_i.write) begin
						state_d.rdata = summary_word[req_i.space];
					end
				end
				OSEIC_OFS_ERR_CTRL: begin
					if (ctrl_live) begin
						if (req_i.write) begin
							state_d.space[req_i.space].error_irq_enable =
								req_i.wdata[OSEIC_IRQ_EN_BIT];
						end else begin
							state_d.rdata[OSEIC_IRQ_EN_BIT] =
								state_q.space[req_i.space].error_irq_enable;
						end
					end
				end
				OSEIC_OFS_MSI_HIGH: begin
					if (error_msi_capable_i) begin
						if (req_i.write) begin
							state_d.space[req_i.space].msi_address_upper =
								req_i.wdata[OSEIC_MSI_HI_W-1:0];
						end else begin
							state_d.rdata[OSEIC_MSI_HI_W-1:0] =
								state_q.space[req_i.space].msi_address_upper;
						end
					end
				end
				default: begin
					state_d.rdata = 32'h00000000;
				end
			endcase
		end
		// An error raises only its own space's interrupt, and only when enabled.
		state_d.irq = 4'h0;
		if (error_event_i && ctrl_live && space_live[error_space_i]) begin
			state_d.irq[error_space_i] =
				state_q.space[error_space_i].error_irq_enable;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int s = 0; s < OSEIC_NUM_SPACES; s++) begin
				state_q.space[s].error_irq_enable  <= OSEIC_IRQ_EN_RST;
				state_q.space[s].msi_address_upper <= OSEIC_MSI_HI_RST;
			end
			state_q.ack   <= 1'b0;
			state_q.rdata <= 32'h00000000;
			state_q.irq   <= 4'h0;
		end else begin
			state_q <= state_d;
		end
	end

	// Outputs; the low address half (with bits 1:0 zero) lives elsewhere.
	assign ack_o   = state_q.ack;
	assign rdata_o = state_q.rdata;
	assign error_irq_o = state_q.irq;
	for (genvar s = 0; s < OSEIC_NUM_SPACES; s++) begin : g_out
		assign msi_address_upper_o[s] = state_q.space[s].msi_address_upper;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks.
	chk_sum_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && !req_i.write && req_i.offset == OSEIC_OFS_OFLOW_SUM
		 && space_live[req_i.space])
		|=> rdata_o == $past(summary_word[req_i.space]))
		else $error("summary read mismatch");

	// Bits 19:16 carry address bits on a high address read, so only that read may set them.
	chk_sum_reserved: assert property (@(posedge clk_i) disable iff (!resetn_i)
		rdata_o[29:20] == 10'h0 && (rdata_o[19:16] == 4'h0
		 || $past(req_i.valid && !req_i.write && req_i.offset == OSEIC_OFS_MSI_HIGH)))
		else $error("reserved read bits nonzero");

	chk_rlm_absent: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && !realm_mgmt_present_i && req_i.space[1])
		|=> rdata_o == 32'h00000000)
		else $error("root or realm page answered without realm management");

	chk_ctrl_dead: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.offset == OSEIC_OFS_ERR_CTRL && !ctrl_live)
		|=> rdata_o == 32'h00000000)
		else $error("error control not read as zero");

	chk_irq_gate: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(error_event_i && ctrl_live && space_live[error_space_i])
		|=> error_irq_o[$past(error_space_i)]
			== $past(state_q.space[error_space_i].error_irq_enable))
		else $error("error interrupt gating wrong");

	chk_ctrl_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.write && req_i.offset == OSEIC_OFS_ERR_CTRL && ctrl_live
		 && space_live[req_i.space])
		##1 (req_i.valid && !req_i.write && req_i.offset == OSEIC_OFS_ERR_CTRL
		 && req_i.space == $past(req_i.space) && ctrl_live && space_live[req_i.space])
		|=> rdata_o == {31'h0, $past(req_i.wdata[OSEIC_IRQ_EN_BIT], 2)})
		else $error("error control write not held");

	chk_hi_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.write && req_i.offset == OSEIC_OFS_MSI_HIGH
		 && error_msi_capable_i && space_live[req_i.space])
		|=> msi_address_upper_o[$past(req_i.space)] == $past(req_i.wdata[19:0]))
		else $error("high address write lost");

	chk_hi_absent: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.offset == OSEIC_OFS_MSI_HIGH && !error_msi_capable_i)
		|=> rdata_o == 32'h00000000 && $stable(msi_address_upper_o))
		else $error("high address answered without capability");

	chk_sum_no_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.write && req_i.offset == OSEIC_OFS_OFLOW_SUM)
		|=> ack_o && rdata_o == 32'h00000000 && $stable(state_q.space))
		else $error("summary write had an effect");

	chk_rlm_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.write && !realm_mgmt_present_i && req_i.space[1])
		|=> $stable(state_q.space))
		else $error("root or realm state written without realm management");

	chk_ctrl_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
		(req_i.valid && req_i.write && req_i.offset == OSEIC_OFS_ERR_CTRL && !ctrl_live)
		|=> $stable(state_q.space))
		else $error("dead error control took a write");

	// An interrupt with no error behind it would send software chasing nothing.
	chk_irq_quiet: assert property (@(posedge clk_i) disable iff (!resetn_i)
		!error_event_i |=> error_irq_o == 4'h0)
		else $error("error interrupt without an error");

	chk_irq_own: assert property (@(posedge clk_i) disable iff (!resetn_i)
		error_event_i |=> (error_irq_o & ~(4'h1 << $past(error_space_i))) == 4'h0)
		else $error("error interrupt raised in a foreign space");

endmodule : oseic_regs

// ---- rtl/oseic_pkg.sv ----
// Package for the overflow summary and error interrupt control register bank.
package oseic_pkg;

	// Register offsets within each feature page.
	localparam logic [11:0] OSEIC_OFS_MSI_HIGH   = 12'h0e4;
	localparam logic [11:0] OSEIC_OFS_ERR_CTRL   = 12'h0f0;
	localparam logic [11:0] OSEIC_OFS_OFLOW_SUM  = 12'h8f0;

	// Field positions and widths.
	localparam int          OSEIC_NUM_INST       = 16;
	localparam int          OSEIC_NUM_SPACES     = 4;
	localparam int          OSEIC_CSU_BIT        = 31;
	localparam int          OSEIC_MEMORY_BANDWIDTH_USAGE_BIT       = 30;
	localparam int          OSEIC_IRQ_EN_BIT     = 0;
	localparam int          OSEIC_MSI_HI_W       = 20;

	// Reset values.
	localparam logic        OSEIC_IRQ_EN_RST     = 1'b0;
	localparam logic [19:0] OSEIC_MSI_HI_RST     = 20'h00000;

	// Security spaces, one feature page each.
	typedef enum logic [1:0] {
		OSEIC_SPACE_SECURE    = 2'b00,
		OSEIC_SPACE_NONSECURE = 2'b01,
		OSEIC_SPACE_ROOT      = 2'b10,
		OSEIC_SPACE_REALM     = 2'b11
	} oseic_space_type;

	// Register access request.
	typedef struct packed {
		logic            valid;
		logic            write;
		oseic_space_type space;
		logic [11:0]     offset;
		logic [31:0]     wdata;
	} oseic_req_type;

	// Per-space overflow flags from the monitors.
	typedef struct packed {
		logic [15:0] inst_flag;
		logic        csu_flag;
		logic        memory_bandwidth_usage_flag;
	} oseic_oflow_type;

	// Per-space writable state.
	typedef struct packed {
		logic        error_irq_enable;
		logic [19:0] msi_address_upper;
	} oseic_space_state_type;

endpackage : oseic_pkg

// ---- bench/oseic_regs_tb_top.sv ----
// Self-checking bench for the overflow summary and error interrupt control registers.
module oseic_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import oseic_pkg::*;

`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end

	logic                   clk_i = 1'b0;
	logic                   resetn_i = 1'b0;
	oseic_req_type          req_i = '0;
	logic                   ack_o;
	logic [31:0]            rdata_o;
	oseic_oflow_type [3:0]  oflow_i = '0;
	logic [3:0]             gate = 4'hf;
	logic                   ev = 1'b0;
	oseic_space_type        es = OSEIC_SPACE_SECURE;
	logic [3:0]             error_irq_o;
	logic [3:0][19:0]       upper_o;
	int                     failures = 0;
	int                     compares = 0;
	logic [31:0]            expq[$];
	logic [31:0]            exp_word;
	logic                   en[4];
	logic [19:0]            hi[4];
	logic [11:0]            ofs[5] = '{OSEIC_OFS_ERR_CTRL, OSEIC_OFS_MSI_HIGH, OSEIC_OFS_OFLOW_SUM,
	                                   12'h0e0, 12'h0f4};

	oseic_regs u_oseic_regs (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .ack_o(ack_o),
		.rdata_o(rdata_o), .oflow_i(oflow_i), .realm_mgmt_present_i(gate[3]),
		.partitioning_present_i(gate[2]), .errors_possible_i(gate[1]),
		.error_msi_capable_i(gate[0]), .error_event_i(ev), .error_space_i(es),
		.error_irq_o(error_irq_o), .msi_address_upper_o(upper_o));

	////////////////////////////////////////////////////////////////////////////////
	// Free-running 250 MHz clock.
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	// One access per call, back to back; the expected answer is queued before the request goes out.
	task automatic acc(input logic w, input int s, input logic [11:0] o, input logic [31:0] d,
		input logic rnd);
		logic        live;
		logic [31:0] e;
		logic [95:0] r;
		@(posedge clk_i);
		#1;
		r = {$urandom, $urandom, $urandom};
		if (rnd) begin
			oflow_i = r[71:0];
			if (r[95:93] == 3'h0) gate = r[91:88];
		end else begin
			gate = 4'hf;
		end
		live = gate[3] || s < 2;
		e = '0;
		if (o == OSEIC_OFS_ERR_CTRL && live && gate[2] && gate[1]) begin
			if (w) en[s] = d[0];
			e = {31'h0, en[s]};
		end
		if (o == OSEIC_OFS_MSI_HIGH && live && gate[0]) begin
			if (w) hi[s] = d[19:0];
			e = {12'h000, hi[s]};
		end
		if (o == OSEIC_OFS_OFLOW_SUM && live)
			e = {oflow_i[s].csu_flag, oflow_i[s].memory_bandwidth_usage_flag, 14'h0000, oflow_i[s].inst_flag};
		expq.push_back(w ? 32'h0 : e);
		req_i = '{1'b1, w, oseic_space_type'(s), o, d};
	endtask : acc

	task automatic print_verdict;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////////
	// Watches the answers; sampling at the falling edge keeps clear of the update edge.
	initial begin
		forever begin
			@(negedge clk_i);
			if (ack_o === 1'b1) begin
				if (expq.size() == 0) begin
					`CHK(ack_o, 1'b0)
				end else begin
					// Popped once here, so a mismatch report cannot consume a second note.
					exp_word = expq.pop_front();
					`CHK(rdata_o, exp_word)
				end
			end
		end
	end

	// Hang guard: the whole run is a few hundred cycles at most.
	initial begin
		#40000;
		failures++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset values, random traffic with changing feature gates, then interrupts.
	initial begin
		void'($urandom(32'he2472263));
		for (int s = 0; s < 4; s++) begin
			en[s] = OSEIC_IRQ_EN_RST;
			hi[s] = OSEIC_MSI_HI_RST;
		end
		repeat (16) @(posedge clk_i);
		#1 resetn_i = 1'b1;
		for (int s = 0; s < 4; s++) acc(1'b0, s, OSEIC_OFS_ERR_CTRL, 32'h0, 1'b0);
		// Random offsets include two unmapped places and writes to the read-only summary.
		repeat (400) acc(1'($urandom), $urandom % 4, ofs[$urandom % 5], $urandom, 1'b1);
		// Directed calls reopen every feature gate in step with their own request.
		// Each space gets its own enable and address; an error only fires its own space.
		for (int s = 0; s < 4; s++) begin
			acc(1'b1, s, OSEIC_OFS_ERR_CTRL, {31'($urandom), 1'b0} | 32'((s + 1) % 2), 1'b0);
			acc(1'b1, s, OSEIC_OFS_MSI_HIGH, $urandom, 1'b0);
		end
		@(posedge clk_i);
		#1 req_i.valid = 1'b0;
		for (int s = 0; s < 4; s++) begin
			`CHK(upper_o[s], hi[s])
			@(posedge clk_i);
			#1;
			ev = 1'b1;
			es = oseic_space_type'(s);
			@(negedge clk_i);
			`CHK(error_irq_o, 4'h0)
			@(posedge clk_i);
			#1 ev = 1'b0;
			@(negedge clk_i);
			`CHK(error_irq_o, en[s] ? 4'(1 << s) : 4'h0)
		end
		// A polling pass: one flagged instance and one flagged monitor type per space.
		for (int s = 0; s < 4; s++) begin
			oflow_i[s] = '{16'h1 << (s * 4), 1'(s % 2), 1'((s + 1) % 2)};
			acc(1'b0, s, OSEIC_OFS_OFLOW_SUM, 32'h0, 1'b0);
		end
		@(posedge clk_i);
		#1 req_i.valid = 1'b0;
		repeat (4) @(posedge clk_i);
		`CHK(expq.size(), 0)
		print_verdict();
	end

endmodule : oseic_regs_tb_top
